// *** design/pb_power_seq.sv ***
/*
 push button power sequencer: debounces an active-low button, drives an
 open-drain power enable of selectable polarity, interrupts the processor and
 honours its active-low shutdown request.
 assumes button_n and shutdown_req_n are synchronous to clk; the open-drain
 wires are resolved outside from enable_out/enable_oe and interrupt_n.
*/
`timescale 1ns/10ps
`include "pb_seq_defines.svh"
module pb_power_seq
   import pb_seq_pkg::*;
#(
   parameter bit ACTIVE_HIGH_EN = 1'b1,
   parameter int TICK_CYCLES    = `TICK_CYCLES,
   parameter int FILTER_CYCLES  = `REQ_FILTER_CYCLES
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // push button and processor
   input  wire logic             button_n,
   input  wire logic             shutdown_req_n,
   // extensions
   input  wire pb_seq_pkg::seq_cfg_t cfg,
   // open-drain outputs
   output pb_seq_pkg::seq_pins_t pins,
   // status
   output logic                  powered
);
   import pb_seq_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);

   // a one-cycle tick would leave the divider without a count to make
   if (TICK_CYCLES < 2) begin : g_tick_chk
      $error("pb_power_seq: TICK_CYCLES must be at least 2");
   end

   // ==========================================================
   // timebase
   logic [TW-1:0] div;
   logic [TW-1:0] next_div;
   logic          tick;
   logic          next_tick;

   always_comb begin
      next_tick = 1'b0;
      next_div  = div + TW'(1);
      if (div >= TW'(TICK_CYCLES - 1)) begin
         next_div  = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div  <= '0;
         tick <= 1'b0;
      end else begin
         div  <= next_div;
         tick <= next_tick;
      end
   end

   // ==========================================================
   // request filter
   logic req_low;

   req_filter #(.CYCLES(FILTER_CYCLES)) u_req_filter (
      .clk     (clk),
      .rst_b   (rst_b),
      .req_n   (shutdown_req_n),
      .req_low (req_low)
   );

   // ==========================================================
   // sequencer
   seq_state_t          state;
   seq_state_t          next_state;
   logic [`TIMER_W-1:0] tmr;
   logic [`TIMER_W-1:0] next_tmr;
   logic                button_q;
   logic                next_powered;
   logic                next_int_n;
   logic                int_n;
   logic [`TIMER_W-1:0] off_limit;
   logic [`TIMER_W-1:0] shut_limit;

   assign off_limit  = `TIMER_W'(`T_OFF_DEBOUNCE_MS) +
                       `TIMER_W'(cfg.off_debounce_extend);
   assign shut_limit = `TIMER_W'(`T_SHUTDOWN_MS) +
                       `TIMER_W'(cfg.shutdown_timeout_extend);

   always_comb begin
      next_state   = state;
      next_tmr     = tmr;
      next_powered = powered;
      next_int_n   = int_n;
      if (tick) begin
         next_tmr = tmr + `TIMER_W'(1);
      end
      case (state)
         IDLE: begin
            next_tmr     = '0;
            next_powered = 1'b0;
            next_int_n   = 1'b1;
            if (!button_n && button_q) begin
               next_state = ON_DB;
            end
         end
         ON_DB: begin
            if (button_n) begin
               next_state = IDLE;
            end else if (tmr >= `TIMER_W'(`T_ON_DEBOUNCE_MS)) begin
               next_state   = BLANK;
               next_powered = 1'b1;
               next_tmr     = '0;
            end
         end
         BLANK: begin
            // request and button both ignored until the window closes
            if (tmr >= `TIMER_W'(`T_BLANK_MS)) begin
               next_tmr = '0;
               if (req_low) begin
                  next_state   = REL_DB;
                  next_powered = 1'b0;
               end else begin
                  next_state = WAIT_REL;
               end
            end
         end
         WAIT_REL: begin
            // still held from power-on: wait for a debounced release
            if (req_low) begin
               next_state   = LOCKOUT;
               next_powered = 1'b0;
               next_tmr     = '0;
            end else if (!button_n) begin
               next_tmr = '0;
            end else if (tmr >= `TIMER_W'(`T_RELEASE_MS)) begin
               next_state = RUN;
            end
         end
         RUN: begin
            next_tmr = '0;
            if (req_low) begin
               next_state   = LOCKOUT;
               next_powered = 1'b0;
            end else if (!button_n && button_q) begin
               next_state = OFF_DB;
            end
         end
         OFF_DB: begin
            if (req_low) begin
               next_state   = LOCKOUT;
               next_powered = 1'b0;
               next_tmr     = '0;
            end else if (button_n) begin
               next_state = RUN;
               next_tmr   = '0;
            end else if (tmr >= off_limit) begin
               next_state = SHUTDOWN;
               next_int_n = 1'b0;
               next_tmr   = '0;
            end
         end
         SHUTDOWN: begin
            if (req_low || tmr >= shut_limit) begin
               next_state   = REL_DB;
               next_powered = 1'b0;
               next_tmr     = '0;
            end
         end
         LOCKOUT: begin
            if (tmr >= `TIMER_W'(`T_LOCKOUT_MS)) begin
               next_state = REL_DB;
               next_tmr   = '0;
            end
         end
         REL_DB: begin
            next_int_n = 1'b1;
            if (!button_n) begin
               next_tmr = '0;
            end else if (tmr >= `TIMER_W'(`T_RELEASE_MS)) begin
               next_state = IDLE;
            end
         end
         default: begin
            next_state   = IDLE;
            next_powered = 1'b0;
            next_int_n   = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state    <= IDLE;
         tmr      <= '0;
         button_q <= 1'b1;
         powered  <= 1'b0;
         int_n    <= 1'b1;
      end else begin
         state    <= next_state;
         tmr      <= next_tmr;
         button_q <= button_n;
         powered  <= next_powered;
         int_n    <= next_int_n;
      end
   end

   // ==========================================================
   // pins: register the open-drain view
   seq_pins_t next_pins;

   always_comb begin
      next_pins.interrupt_n = next_int_n;
      // high variant pulls low when off; low variant pulls low when on
      next_pins.enable_oe   = ACTIVE_HIGH_EN ? ~next_powered : next_powered;
      next_pins.enable_out  = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pins.interrupt_n <= 1'b1;
         pins.enable_out  <= 1'b0;
         pins.enable_oe   <= ACTIVE_HIGH_EN;
      end else begin
         pins <= next_pins;
      end
   end
endmodule : pb_power_seq

// *** design/pb_seq_defines.svh ***
/*
 constant definitions for the push button power sequencer: timing figures in their
 own units, derived cycle counts at the 50 MHz system clock.
 assumes a single clock of CLK_HZ and that every includer uses these names only.
*/
// Summary of operation
// - off debounce: 32ms plus extension, continuous low
// - debounce done: interrupt low, start shutdown timeout
// - shutdown timeout 128ms plus configurable extension
// - request low releases enable, cancels timeout
// - button release debounced 32ms after power-off
// - return to idle, enable released, await press
// - request low at blanking end aborts power-on
// - request low in normal run releases enable
// - button ignored 256ms after request release
// - enable polarity selectable, timing identical
// - request honoured only after 30us low
// - enable asserted after 128ms continuous press
// - request and button ignored during 512ms blanking
// - enable released from reset onward
`ifndef PB_SEQ_DEFINES_SVH
`define PB_SEQ_DEFINES_SVH

`define CLK_HZ             50000000
// timebase tick period
`define TICK_US            1000
`define TICK_CYCLES        ((`CLK_HZ / 1000000) * `TICK_US)
// times below are in ms, counted in timebase ticks of 1 ms
`define T_ON_DEBOUNCE_MS   128
`define T_OFF_DEBOUNCE_MS  32
`define T_RELEASE_MS       32
`define T_BLANK_MS         512
`define T_SHUTDOWN_MS      128
`define T_LOCKOUT_MS       256
// request glitch filter, in us, counted in clock cycles (rounded down)
`define T_REQ_FILTER_US    30
`define REQ_FILTER_CYCLES  ((`T_REQ_FILTER_US * (`CLK_HZ / 1000000) + 0) )
`define TIMER_W            16
`define EXT_W              12

`endif

// *** design/pb_seq_pkg.sv ***
/*
 types shared by the push button power sequencer.
 assumes pb_seq_defines.svh supplies widths.
*/
`include "pb_seq_defines.svh"
package pb_seq_pkg;

   typedef enum logic [8:0] {
      IDLE     = 9'h001,
      ON_DB    = 9'h002,
      WAIT_REL = 9'h004,
      BLANK    = 9'h008,
      RUN      = 9'h010,
      OFF_DB   = 9'h020,
      SHUTDOWN = 9'h040,
      LOCKOUT  = 9'h080,
      REL_DB   = 9'h100
   } seq_state_t;

   // capacitor-set extensions as counts of 1 ms ticks
   typedef struct packed {
      logic [`EXT_W-1:0] off_debounce_extend;
      logic [`EXT_W-1:0] shutdown_timeout_extend;
   } seq_cfg_t;

   typedef struct packed {
      logic enable_out;
      logic enable_oe;
      logic interrupt_n;
   } seq_pins_t;

endpackage : pb_seq_pkg

// *** design/req_filter.sv ***
/*
 glitch filter for the active-low shutdown request: the filtered level goes low
 only after the raw level has stayed low for CYCLES clocks; it rises at once.
 assumes the request is synchronous to clk.
*/
`timescale 1ns/10ps
`include "pb_seq_defines.svh"
module req_filter #(
   parameter int CYCLES = `REQ_FILTER_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // request
   input  wire logic req_n,
   output logic      req_low
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_req_low;

   // refuse a filter length that could never pass a request
   if (CYCLES < 1) begin : g_cycles_chk
      $error("req_filter: CYCLES must be at least 1");
   end

   always_comb begin
      next_cnt     = cnt;
      next_req_low = req_low;
      if (req_n) begin
         next_cnt     = '0;
         next_req_low = 1'b0;
      end else if (cnt >= W'(CYCLES - 1)) begin
         next_req_low = 1'b1;
      end else begin
         next_cnt = cnt + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt     <= '0;
         req_low <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         req_low <= next_req_low;
      end
   end
endmodule : req_filter

// *** testbench/pb_seq_sva.sv ***
/*
 assertions on the ports of pb_power_seq.
 assumes one clock and counts scaled by the same parameters as the design.
*/
`timescale 1ns/10ps
module pb_seq_sva
   import pb_seq_pkg::*;
#(
   parameter bit ACTIVE_HIGH_EN = 1'b1,
   parameter int TICK_CYCLES    = 10,
   parameter int FILTER_CYCLES  = 4
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // ports of the block
   input  wire logic                  button_n,
   input  wire logic                  shutdown_req_n,
   input  wire pb_seq_pkg::seq_cfg_t  cfg,
   input  wire pb_seq_pkg::seq_pins_t pins,
   input  wire logic                  powered
);
   int low_cnt, req_cnt, int_cnt, next_low_cnt, next_req_cnt, next_int_cnt;
   // =====
   // run lengths of each cause
   always_comb begin
      next_low_cnt = button_n ? 0 : low_cnt + 1;
      next_req_cnt = shutdown_req_n ? 0 : req_cnt + 1;
      next_int_cnt = (!pins.interrupt_n && powered) ? int_cnt + 1 : 0;
   end
   always_ff @(posedge clk) begin
      low_cnt <= next_low_cnt;
      req_cnt <= next_req_cnt;
      int_cnt <= next_int_cnt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // =====
   // assertions
   a_reset_idle: assert property ($rose(rst_b) |-> !powered && pins.interrupt_n)
      else $error("outputs not idle after reset");
   a_enable_polarity: assert property (pins.enable_oe == (ACTIVE_HIGH_EN ^ powered))
      else $error("enable drive wrong");
   a_enable_out_low: assert property (pins.enable_out == 1'b0)
      else $error("enable data not low");
   a_on_held: assert property ($rose(powered) |-> low_cnt >= 127 * TICK_CYCLES)
      else $error("power on too early");
   a_off_held: assert property ($fell(pins.interrupt_n)
      |-> low_cnt >= (31 + cfg.off_debounce_extend) * TICK_CYCLES)
      else $error("interrupt too early");
   a_int_powered: assert property ($fell(pins.interrupt_n) |-> powered)
      else $error("interrupt while off");
   a_timeout_bound: assert property (int_cnt
      <= (129 + cfg.shutdown_timeout_extend) * TICK_CYCLES + 3)
      else $error("timeout overran");
   a_req_filtered: assert property ($fell(powered) && $past(pins.interrupt_n)
      |-> req_cnt >= FILTER_CYCLES)
      else $error("short request acted on");
   c_on: cover property ($rose(powered));
   c_int: cover property ($fell(pins.interrupt_n));
   c_off: cover property ($fell(powered));
endmodule : pb_seq_sva

bind pb_power_seq pb_seq_sva #(.ACTIVE_HIGH_EN(ACTIVE_HIGH_EN), .TICK_CYCLES(TICK_CYCLES),
   .FILTER_CYCLES(FILTER_CYCLES)) u_sva (.clk(clk), .rst_b(rst_b), .button_n(button_n),
   .shutdown_req_n(shutdown_req_n), .cfg(cfg), .pins(pins), .powered(powered));

// *** testbench/proc_model.sv ***
/*
 processor model on the far side of the shutdown interrupt.
 assumes the request wire has a pull-up, so released means high.
*/
`timescale 1ns/10ps
module proc_model (
   // clock
   input  wire logic        clk,
   // interrupt in; mode 0 keeps high, 1 answers after delay, 3 holds low
   input  wire logic        interrupt_n,
   input  wire logic [1:0]  mode,
   input  wire logic [15:0] delay,
   // request out
   output logic             req_n
);
   int cnt = 0;
   initial req_n = 1'b1;
   always @(posedge clk) begin
      cnt <= interrupt_n ? 0 : cnt + 1;
      req_n <= !(mode == 2'h3 || (mode == 2'h1 && !interrupt_n && cnt >= delay));
   end
endmodule : proc_model

// *** testbench/tb_top.sv ***
/*
 testbench for pb_power_seq, both enable polarities, with a processor model.
 assumes ticks of 10 clocks and a request filter of 4 clocks.
*/
`timescale 1ns/10ps
module tb_top;
   import pb_seq_pkg::*;
   localparam int T = 10;
   localparam int F = 4;
   logic        clk, rst_b, button_n, req_n, powered, powered_l;
   logic [1:0]  mode;
   logic [15:0] delay;
   seq_cfg_t    cfg;
   seq_pins_t   pins, pins_l;
   int          error_cnt, comparisons, n, d;
   pb_power_seq #(.ACTIVE_HIGH_EN(1'b1), .TICK_CYCLES(T), .FILTER_CYCLES(F)) u_dut (
      .clk(clk), .rst_b(rst_b), .button_n(button_n), .shutdown_req_n(req_n), .cfg(cfg),
      .pins(pins), .powered(powered));
   pb_power_seq #(.ACTIVE_HIGH_EN(1'b0), .TICK_CYCLES(T), .FILTER_CYCLES(F)) u_dut_low (
      .clk(clk), .rst_b(rst_b), .button_n(button_n), .shutdown_req_n(req_n), .cfg(cfg),
      .pins(pins_l), .powered(powered_l));
   proc_model u_proc (.clk(clk), .interrupt_n(pins.interrupt_n), .mode(mode),
      .delay(delay), .req_n(req_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // =====
   // helpers
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // bounded wait on powered (sel 0) or interrupt (sel 1), cycles left in n
   task automatic wt(bit sel, logic v);
      n = 0;
      while ((sel ? pins.interrupt_n : powered) !== v) begin
         @(negedge clk);
         n++;
         if (n > 20000) begin
            error_cnt++;
            summarize();
         end
      end
   endtask : wt
   // one tick of slack each way: the timebase phase is free
   function automatic logic near(int e);
      return n >= e - T - 1 && n <= e + T + 3;
   endfunction : near
   task automatic cyc(int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   task automatic btn(logic v);
      @(posedge clk) button_n <= v;
   endtask : btn
   task automatic md(logic [1:0] v);
      @(posedge clk) mode <= v;
   endtask : md
   task automatic st(logic e);
      check("powered", powered, e);
      check("enable_oe", pins.enable_oe, !e);
      check("enable_out", {pins.enable_out, pins_l.enable_out}, 2'h0);
      check("low_variant", {powered_l, pins_l.enable_oe}, {e, e});
   endtask : st
   task automatic power_on();
      btn(0);
      wt(0, 1);
      check("on_time", near(128 * T), 1);
      btn(1);
   endtask : power_on
   task automatic press_off();
      btn(0);
      wt(1, 0);
      check("off_time", near((32 + cfg.off_debounce_extend) * T), 1);
      check("int_on", powered, 1);
   endtask : press_off
   task automatic to_idle();
      btn(1);
      cyc(40 * T);
      check("int_idle", pins.interrupt_n, 1);
      st(0);
   endtask : to_idle
   // =====
   // main sequence
   initial begin
      rst_b = 1'b0;
      button_n = 1'b1;
      mode = 2'h0;
      delay = 16'h0;
      cfg = '0;
      void'($urandom(98211));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      cyc(2);
      st(0);
      check("int_rst", pins.interrupt_n, 1);
      btn(0);
      cyc($urandom_range(20, 120) * T);
      btn(1);
      cyc(T);
      st(0);
      repeat (2) begin
         @(posedge clk) cfg <= seq_cfg_t'({12'($urandom_range(0, 3)), 12'($urandom_range(0, 3))});
         power_on();
         cyc(548 * T);
         st(1);
         btn(0);
         cyc((30 + cfg.off_debounce_extend) * T);
         btn(1);
         cyc(T);
         check("off_short", pins.interrupt_n, 1);
         d = $urandom_range(0, 20);
         delay <= 16'(d);
         md(1);
         press_off();
         wt(0, 0);
         check("req_off", n >= d + F + 1 && n <= d + F + 3, 1);
         md(0);
         to_idle();
         power_on();
         cyc(548 * T);
         md(3);
         cyc(F - 1);
         md(0);
         cyc(10);
         st(1);
         md(3);
         wt(0, 0);
         check("req_run", n >= F + 2 && n <= F + 4, 1);
         md(0);
         btn(0);
         cyc(200 * T);
         btn(1);
         cyc(T);
         st(0);
         cyc(100 * T);
         power_on();
         cyc(548 * T);
         press_off();
         wt(0, 0);
         check("kill_time", near((128 + cfg.shutdown_timeout_extend) * T), 1);
         to_idle();
         md(3);
         power_on();
         wt(0, 0);
         check("abort", near(512 * T), 1);
         md(0);
         to_idle();
      end
      // reset during blanking while powered: enable must drop at once
      power_on();
      @(posedge clk) rst_b <= 1'b0;
      cyc(2);
      st(0);
      check("int_rst_mid", pins.interrupt_n, 1);
      @(posedge clk) rst_b <= 1'b1;
      cyc(2);
      st(0);
      power_on();
      st(1);
      summarize();
   end
endmodule : tb_top
